// ---- logic/rpw_device.sv ----
// encoder end: power modes, storage registers and motion wake
// Functional notes
// - config write 17H enters low power mode
// - angle valid only when locked after resume
// - reduced power freezes angle and gain state
// - full power loss gives 2ms cold start
// - host re-sleeps only after valid angle
// - polling only with retention supply present
// - trim reload command 19 fetches valid trim
// - trim copied to storage only if wake-enable
// - storage refreshed continuously while powered
// - command 3 stores current angle as reference
// - no reference means wake at every restored startup, none at cold start
// - storage frozen when main supply drops
// - restore, compare, wake if above threshold
// - wake pulse low 10 to 17 us
// - no wake when difference within threshold
// - no wake before 250 us settling
// - wake is open drain, active low
// - locked flag set when tracking synchronised
// - host programs threshold by customer write
`timescale 1ns/100ps
module rpw_device #(
  parameter int unsigned COLD_CYC = rpw_pkg::COLD_CYC,
  parameter int unsigned SETTLE_CYC = rpw_pkg::SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  rpw_if.device lnk,
  input wire logic [7:0] magnet_angle_i,
  input wire logic [5:0] gain_i,
  input wire logic [8:0] nv_trim_i,
  output logic low_power_o,
  output logic [7:0] turns_o,
  output logic wake_event_o
);
  // *****************************************************
  // helpers
  // *****************************************************
  // shortest distance on a 256 code circle
  function automatic logic [7:0] ang_dist(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = a - b;
    ang_dist = d[7] ? 8'(-d) : d;
  endfunction

  // *****************************************************
  // state
  // *****************************************************
  rpw_pkg::rpw_dev_state_t state;
  logic [rpw_pkg::CNT_W-1:0] cnt;
  logic [7:0] trk_cnt;
  logic [7:0] track_angle;
  logic [5:0] gain;
  logic [7:0] turns;
  logic [1:0] hyst;
  logic [2:0] gain_set;
  logic [7:0] thr;
  logic trim_valid;
  logic wake_en;
  logic locked;
  logic wake_drv;
  logic wake_evt;
  // retained storage, kept by the retention supply
  logic s_valid;
  logic [5:0] s_gain;
  logic [7:0] s_angle;
  logic [7:0] s_turns;
  logic [1:0] s_hyst;
  logic [7:0] s_thr;
  logic [2:0] s_gain_set;
  logic [7:0] s_ref;
  logic s_ref_valid;

  // *****************************************************
  // decode
  // *****************************************************
  wire cmd_take = lnk.cmd_valid & lnk.cmd_ready;
  wire take_cfg = cmd_take & (lnk.cmd_code == rpw_pkg::CMD_WRITE_CONFIG);
  wire take_trim = cmd_take & (lnk.cmd_code == rpw_pkg::CMD_RST_TRIM);
  wire take_ref = cmd_take & (lnk.cmd_code == rpw_pkg::CMD_STORE_REF);
  wire take_cust = cmd_take & (lnk.cmd_code == rpw_pkg::CMD_CUST_WRITE);
  wire cfg_lp = lnk.cmd_data[rpw_pkg::CFG_LP_BIT];
  wire is_active = (state == rpw_pkg::ST_ACTIVE);
  wire is_lowpwr = (state == rpw_pkg::ST_LOWPWR);
  // tracking halts outside these states, so the angle stays put in cold start and low power
  wire tracking_on = (state == rpw_pkg::ST_SETTLE) | (state == rpw_pkg::ST_WAKE) | is_active;
  wire powered_up = tracking_on | is_lowpwr;
  wire step_due = tracking_on & (trk_cnt == 8'(rpw_pkg::TRACK_CYC - 1));
  wire [7:0] fwd = magnet_angle_i - track_angle;
  wire step_up = step_due & (fwd != 8'h00) & ~fwd[7];
  wire step_dn = step_due & fwd[7];
  wire [7:0] next_track = step_up ? 8'(track_angle + 8'h01) : (step_dn ? 8'(track_angle - 8'h01) : track_angle);
  // restore path needs retained content and the retention supply
  wire can_restore = lnk.retention_ok & s_valid;
  wire wake_needed = ~s_ref_valid | (ang_dist(track_angle, s_ref) > thr);
  wire settle_done = (cnt == rpw_pkg::CNT_W'(SETTLE_CYC - 1));
  wire cold_done = (cnt == rpw_pkg::CNT_W'(COLD_CYC - 1));
  wire wake_done = (cnt == rpw_pkg::CNT_W'(rpw_pkg::WAKE_CYC - 1));
  // refresh only while the main supply is good and wake storage is on
  wire refresh = lnk.supply_ok & powered_up & wake_en & trim_valid;

  assign lnk.cmd_ready = is_active | is_lowpwr;
  assign lnk.angle = track_angle;
  assign lnk.locked = locked;
  assign lnk.angle_valid = locked & is_active;
  assign lnk.wake_out = 1'b0;
  assign lnk.wake_oe_n = ~wake_drv;
  assign low_power_o = is_lowpwr;
  assign turns_o = turns;
  assign wake_event_o = wake_evt;

  // *****************************************************
  // power state sequencer
  // *****************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= rpw_pkg::ST_OFF;
      cnt <= '0;
      wake_drv <= 1'b0;
      wake_evt <= 1'b0;
    end else begin
      wake_evt <= 1'b0;
      cnt <= cnt + 1'b1;
      if (!lnk.supply_ok) begin
        state <= rpw_pkg::ST_OFF;
        wake_drv <= 1'b0;
        cnt <= '0;
      end else begin
        case (state)
          rpw_pkg::ST_OFF: begin
            cnt <= '0;
            state <= can_restore ? rpw_pkg::ST_SETTLE : rpw_pkg::ST_COLD;
          end
          rpw_pkg::ST_COLD: begin
            if (cold_done) begin
              state <= rpw_pkg::ST_ACTIVE;
            end
          end
          rpw_pkg::ST_SETTLE: begin
            // compare only after the angle has had time to settle
            if (settle_done) begin
              cnt <= '0;
              if (wake_needed) begin
                state <= rpw_pkg::ST_WAKE;
                wake_drv <= 1'b1;
                wake_evt <= 1'b1;
              end else begin
                state <= rpw_pkg::ST_ACTIVE;
              end
            end
          end
          rpw_pkg::ST_WAKE: begin
            if (wake_done) begin
              state <= rpw_pkg::ST_ACTIVE;
              wake_drv <= 1'b0;
            end
          end
          rpw_pkg::ST_ACTIVE: begin
            if (take_cfg & cfg_lp) begin
              state <= rpw_pkg::ST_LOWPWR;
            end
          end
          rpw_pkg::ST_LOWPWR: begin
            if (take_cfg & ~cfg_lp) begin
              state <= rpw_pkg::ST_ACTIVE;
            end
          end
          default: begin
            state <= rpw_pkg::ST_OFF;
            wake_drv <= 1'b0;
          end
        endcase
      end
    end
  end

  // *****************************************************
  // tracking converter and live values
  // *****************************************************
  // cold start clears everything, restore reloads from storage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trk_cnt <= '0;
      track_angle <= '0;
      gain <= '0;
      turns <= '0;
      hyst <= '0;
      gain_set <= '0;
      thr <= '0;
      trim_valid <= 1'b0;
      wake_en <= 1'b0;
      locked <= 1'b0;
    end else if (state == rpw_pkg::ST_OFF) begin
      trk_cnt <= '0;
      locked <= 1'b0;
      if (lnk.supply_ok) begin
        track_angle <= can_restore ? s_angle : 8'h00;
        gain <= can_restore ? s_gain : 6'h00;
        turns <= can_restore ? s_turns : 8'h00;
        hyst <= can_restore ? s_hyst : 2'h0;
        gain_set <= can_restore ? s_gain_set : 3'h0;
        thr <= can_restore ? s_thr : 8'h00;
        trim_valid <= can_restore;
        wake_en <= can_restore;
      end
    end else begin
      trk_cnt <= step_due ? 8'h00 : (tracking_on ? 8'(trk_cnt + 8'h01) : trk_cnt);
      track_angle <= next_track;
      locked <= tracking_on & (next_track == magnet_angle_i);
      if (tracking_on) begin
        gain <= gain_i;
      end
      if (step_up & (track_angle == 8'hFF)) begin
        turns <= 8'(turns + 8'h01);
      end else if (step_dn & (track_angle == 8'h00)) begin
        turns <= 8'(turns - 8'h01);
      end
      if (take_cfg) begin
        hyst <= lnk.cmd_data[rpw_pkg::CFG_HYST_LSB +: 2];
        gain_set <= lnk.cmd_data[rpw_pkg::CFG_GAIN_LSB +: 3];
      end
      if (take_cust) begin
        thr <= lnk.cmd_data;
      end
      if (take_trim) begin
        trim_valid <= 1'b1;
        wake_en <= nv_trim_i[rpw_pkg::TRIM_WAKE_EN_BIT];
      end
    end
  end

  // *****************************************************
  // retained storage registers
  // *****************************************************
  // contents hold with the main supply gone; losing retention clears s_valid and s_ref_valid
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_valid <= 1'b0;
      s_gain <= '0;
      s_angle <= '0;
      s_turns <= '0;
      s_hyst <= '0;
      s_thr <= '0;
      s_gain_set <= '0;
      s_ref <= '0;
      s_ref_valid <= 1'b0;
    end else if (!lnk.retention_ok) begin
      s_valid <= 1'b0;
      s_ref_valid <= 1'b0;
    end else begin
      if (refresh) begin
        s_valid <= 1'b1;
        s_gain <= gain;
        s_angle <= track_angle;
        s_turns <= turns;
        s_hyst <= hyst;
        s_thr <= thr;
        s_gain_set <= gain_set;
      end
      if (take_ref) begin
        s_ref <= track_angle;
        s_ref_valid <= 1'b1;
      end
    end
  end
endmodule

// ---- logic/rpw_host.sv ----
// host end: supply pulsing, setup commands and wake capture
`timescale 1ns/100ps
module rpw_host #(
  parameter int unsigned SETTLE_CYC = rpw_pkg::SETTLE_CYC,
  parameter int unsigned OFF_CYC = rpw_pkg::HOST_OFF_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  rpw_if.host lnk,
  input wire logic [7:0] threshold_i,
  input wire logic poll_i,
  input wire logic lp_i,
  output logic [7:0] angle_o,
  output logic angle_valid_o,
  output logic setup_done_o,
  output logic wake_seen_o
);
  // *****************************************************
  // state
  // *****************************************************
  rpw_pkg::rpw_host_state_t state;
  logic [rpw_pkg::CNT_W-1:0] cnt;
  logic supply;
  logic cmd_valid;
  logic [4:0] cmd_code;
  logic [7:0] cmd_data;
  logic lp_sent;
  logic wake_prev;
  logic wake_seen;

  wire sent = cmd_valid & lnk.cmd_ready;
  wire idle = ~cmd_valid;
  wire in_run = (state == rpw_pkg::H_RUN);
  // low power change; entry only once the angle is valid
  wire lp_change = in_run & idle & (lp_i != lp_sent) & (~lp_i | lnk.angle_valid);
  wire on_done = (cnt >= rpw_pkg::CNT_W'(SETTLE_CYC)) & lnk.angle_valid;
  wire off_done = (cnt == rpw_pkg::CNT_W'(OFF_CYC - 1));

  assign lnk.supply_ok = supply;
  assign lnk.retention_ok = 1'b1;
  assign lnk.cmd_valid = cmd_valid;
  assign lnk.cmd_code = cmd_code;
  assign lnk.cmd_data = cmd_data;
  assign setup_done_o = in_run | (state == rpw_pkg::H_ON) | (state == rpw_pkg::H_OFF);
  assign wake_seen_o = wake_seen;

  // *****************************************************
  // command sequencer and supply pulsing
  // *****************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= rpw_pkg::H_BOOT;
      cnt <= '0;
      supply <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_code <= '0;
      cmd_data <= '0;
      lp_sent <= 1'b0;
    end else begin
      cnt <= cnt + 1'b1;
      if (sent) begin
        cmd_valid <= 1'b0;
      end
      case (state)
        rpw_pkg::H_BOOT: begin
          supply <= 1'b1;
          state <= rpw_pkg::H_TRIM;
          cmd_valid <= 1'b1;
          cmd_code <= rpw_pkg::CMD_RST_TRIM;
          cmd_data <= 8'h00;
        end
        rpw_pkg::H_TRIM: begin
          if (sent) begin
            state <= rpw_pkg::H_THR;
            cmd_valid <= 1'b1;
            cmd_code <= rpw_pkg::CMD_CUST_WRITE;
            cmd_data <= threshold_i;
          end
        end
        rpw_pkg::H_THR: begin
          // reference waits for a tracked angle so it is meaningful
          if (idle & lnk.angle_valid) begin
            state <= rpw_pkg::H_REF;
            cmd_valid <= 1'b1;
            cmd_code <= rpw_pkg::CMD_STORE_REF;
            cmd_data <= 8'h00;
          end
        end
        rpw_pkg::H_REF: begin
          if (sent) begin
            state <= rpw_pkg::H_RUN;
          end
        end
        rpw_pkg::H_RUN: begin
          cnt <= '0;
          if (lp_change) begin
            cmd_valid <= 1'b1;
            cmd_code <= rpw_pkg::CMD_WRITE_CONFIG;
            cmd_data <= {7'h00, lp_i};
            lp_sent <= lp_i;
          end else if (poll_i & idle & ~lp_sent & lnk.angle_valid) begin
            state <= rpw_pkg::H_OFF;
            supply <= 1'b0;
          end
        end
        rpw_pkg::H_OFF: begin
          if (off_done) begin
            state <= rpw_pkg::H_ON;
            supply <= 1'b1;
            cnt <= '0;
          end
        end
        rpw_pkg::H_ON: begin
          if (on_done) begin
            cnt <= '0;
            if (poll_i) begin
              state <= rpw_pkg::H_OFF;
              supply <= 1'b0;
            end else begin
              state <= rpw_pkg::H_RUN;
            end
          end
        end
        default: begin
          state <= rpw_pkg::H_BOOT;
        end
      endcase
    end
  end

  // *****************************************************
  // angle readout and wake edge capture
  // *****************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      angle_o <= '0;
      angle_valid_o <= 1'b0;
      wake_prev <= 1'b1;
      wake_seen <= 1'b0;
    end else begin
      angle_valid_o <= lnk.angle_valid;
      if (lnk.angle_valid) begin
        angle_o <= lnk.angle;
      end
      wake_prev <= lnk.wake_line;
      wake_seen <= wake_prev & ~lnk.wake_line;
    end
  end
endmodule

// ---- pkg/rpw_if.sv ----
// link between the encoder power/wake logic and its host
`timescale 1ns/100ps
interface rpw_if;
  logic supply_ok;
  logic retention_ok;
  logic cmd_valid;
  logic [4:0] cmd_code;
  logic [7:0] cmd_data;
  logic cmd_ready;
  logic [7:0] angle;
  logic locked;
  logic angle_valid;
  logic wake_out;
  logic wake_oe_n;
  logic wake_line;

  // open drain line with external pull-up
  assign wake_line = wake_oe_n ? 1'b1 : wake_out;

  modport device (
    input supply_ok, retention_ok, cmd_valid, cmd_code, cmd_data,
    output cmd_ready, angle, locked, angle_valid, wake_out, wake_oe_n
  );
  modport host (
    output supply_ok, retention_ok, cmd_valid, cmd_code, cmd_data,
    input cmd_ready, angle, locked, angle_valid, wake_line
  );
endinterface

// ---- pkg/rpw_pkg.sv ----
// shared constants and types for the reduced power wake control ends
package rpw_pkg;
  // *****************************************************
  // serial command codes
  // *****************************************************
  localparam logic [4:0] CMD_WRITE_CONFIG = 5'h17;
  localparam logic [4:0] CMD_RST_TRIM = 5'h13;
  localparam logic [4:0] CMD_STORE_REF = 5'h03;
  localparam logic [4:0] CMD_CUST_WRITE = 5'h10;

  // *****************************************************
  // field positions
  // *****************************************************
  localparam int unsigned CFG_LP_BIT = 0;
  localparam int unsigned CFG_HYST_LSB = 1;
  localparam int unsigned CFG_GAIN_LSB = 3;
  localparam int unsigned TRIM_WAKE_EN_BIT = 8;

  // *****************************************************
  // timing, 125 MHz clock
  // *****************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TRACK_STEP_NS = 1150;
  localparam int unsigned WAKE_MIN_NS = 10000;
  localparam int unsigned WAKE_MAX_NS = 17000;
  localparam int unsigned SETTLE_NS = 250000;
  localparam int unsigned COLD_NS = 2000000;
  localparam int unsigned TRACK_CYC = (TRACK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYC = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_MAX_CYC = WAKE_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned COLD_CYC = (COLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOST_OFF_CYC = 12500;
  localparam int unsigned CNT_W = 20;

  // *****************************************************
  // state machines
  // *****************************************************
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_COLD = 3'h4,
    ST_SETTLE = 3'h1,
    ST_WAKE = 3'h3,
    ST_ACTIVE = 3'h2,
    ST_LOWPWR = 3'h6
  } rpw_dev_state_t;

  typedef enum logic [2:0] {
    H_BOOT = 3'h0,
    H_TRIM = 3'h1,
    H_THR = 3'h3,
    H_REF = 3'h2,
    H_RUN = 3'h6,
    H_OFF = 3'h7,
    H_ON = 3'h5
  } rpw_host_state_t;
endpackage

// ---- testbench/rpw_chk.sv ----
// checker for the power and wake link between host and encoder
`timescale 1ns/100ps
module rpw_chk #(
  parameter int unsigned SETTLE_CYC = 40
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic supply_ok,
  input wire logic retention_ok,
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_code,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ready,
  input wire logic [7:0] angle,
  input wire logic locked,
  input wire logic angle_valid,
  input wire logic wake_out,
  input wire logic wake_oe_n,
  input wire logic wake_line
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ****************************************
  // helper counters
  // ****************************************
  logic [19:0] on_cnt;
  logic [19:0] lo_cnt;
  logic [1:0] wk_cnt;
  logic wake_q;
  logic trim_done;
  logic saw_valid;
  wire wake_fall = wake_q & ~wake_oe_n;
  wire trim_take = cmd_valid & cmd_ready & (cmd_code == rpw_pkg::CMD_RST_TRIM);

  // on_cnt and wk_cnt restart on every supply drop, lo_cnt on every wake release, so one run holds one power-on
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      on_cnt <= 20'h00000;
      lo_cnt <= 20'h00000;
      wk_cnt <= 2'h0;
      wake_q <= 1'b1;
      trim_done <= 1'b0;
      saw_valid <= 1'b0;
    end else begin
      on_cnt <= supply_ok ? on_cnt + 20'h00001 : 20'h00000;
      lo_cnt <= wake_oe_n ? 20'h00000 : lo_cnt + 20'h00001;
      wk_cnt <= !supply_ok ? 2'h0 : (wk_cnt + {1'b0, wake_fall & (wk_cnt != 2'h3)});
      wake_q <= wake_oe_n;
      trim_done <= trim_done | trim_take;
      saw_valid <= supply_ok & (saw_valid | angle_valid);
    end
  end

  // ****************************************
  // properties
  // ****************************************
  property p_wake_len;
    $rose(wake_oe_n) |-> lo_cnt >= rpw_pkg::WAKE_CYC && lo_cnt <= rpw_pkg::WAKE_MAX_CYC;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake pulse length off");
  property p_no_early;
    $fell(wake_oe_n) |-> on_cnt >= SETTLE_CYC;
  endproperty
  a_no_early: assert property (p_no_early) else $error("wake before settling");
  property p_ready;
    cmd_ready |-> on_cnt >= SETTLE_CYC;
  endproperty
  a_ready: assert property (p_ready) else $error("ready too soon after power on");
  property p_drop;
    !supply_ok |=> !cmd_ready && wake_oe_n;
  endproperty
  a_drop: assert property (p_drop) else $error("device active without supply");
  property p_lp;
    cmd_valid && cmd_ready && angle_valid && cmd_code == rpw_pkg::CMD_WRITE_CONFIG
      && cmd_data[rpw_pkg::CFG_LP_BIT] |=> !angle_valid;
  endproperty
  a_lp: assert property (p_lp) else $error("low power entry missed");
  property p_lock;
    angle_valid |-> locked;
  endproperty
  a_lock: assert property (p_lock) else $error("angle valid while unlocked");
  property p_od;
    !wake_oe_n |-> !wake_out && supply_ok;
  endproperty
  a_od: assert property (p_od) else $error("wake line driven high");
  property p_once;
    wk_cnt <= 2'h1;
  endproperty
  a_once: assert property (p_once) else $error("two wakes in one power on");
  property p_trim;
    cmd_valid && !trim_done |-> cmd_code == rpw_pkg::CMD_RST_TRIM;
  endproperty
  a_trim: assert property (p_trim) else $error("command before trim reload");
  property p_ref;
    cmd_valid && cmd_ready && cmd_code == rpw_pkg::CMD_STORE_REF |-> angle_valid;
  endproperty
  a_ref: assert property (p_ref) else $error("reference stored from bad angle");
  property p_resleep;
    $fell(supply_ok) |-> saw_valid;
  endproperty
  a_resleep: assert property (p_resleep) else $error("supply cut before valid angle");
endmodule

// ---- testbench/tb.sv ----
// self-checking bench joining host and encoder ends
`timescale 1ns/100ps
module tb;
  typedef struct {
    logic [7:0] ref_a;
    logic [7:0] new_a;
    logic [7:0] thr;
    logic [8:0] trim;
    logic wake;
  } rpw_row_t;
  localparam int unsigned SET_C = 40;
  logic clk_i;
  logic rstn_i;
  logic [7:0] magnet;
  logic [7:0] thr;
  logic [8:0] trim;
  logic poll;
  logic lp;
  logic low_power;
  logic wake_event;
  logic [7:0] angle_o;
  logic angle_valid_o;
  logic setup_done;
  logic wake_seen;
  logic [7:0] turns;
  int err_total;
  int checks_done;
  rpw_row_t rows [6];

  rpw_if lnk();
  rpw_device #(.COLD_CYC(50), .SETTLE_CYC(SET_C)) u_rpw_device (.clk_i(clk_i), .rstn_i(rstn_i),
    .lnk(lnk), .magnet_angle_i(magnet), .gain_i(6'h20), .nv_trim_i(trim), .low_power_o(low_power),
    .turns_o(turns), .wake_event_o(wake_event));
  rpw_host #(.SETTLE_CYC(SET_C), .OFF_CYC(20)) u_rpw_host (.clk_i(clk_i), .rstn_i(rstn_i),
    .lnk(lnk), .threshold_i(thr), .poll_i(poll), .lp_i(lp), .angle_o(angle_o),
    .angle_valid_o(angle_valid_o), .setup_done_o(setup_done), .wake_seen_o(wake_seen));
  rpw_chk #(.SETTLE_CYC(SET_C)) u_rpw_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .supply_ok(lnk.supply_ok), .retention_ok(lnk.retention_ok), .cmd_valid(lnk.cmd_valid),
    .cmd_code(lnk.cmd_code), .cmd_data(lnk.cmd_data), .cmd_ready(lnk.cmd_ready), .angle(lnk.angle),
    .locked(lnk.locked), .angle_valid(lnk.angle_valid), .wake_out(lnk.wake_out),
    .wake_oe_n(lnk.wake_oe_n), .wake_line(lnk.wake_line));

  // ****************************************
  // clock, watchdog and shared tasks
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // rows need about 30k cycles, so 100k leaves slack
  initial begin
    #(8 * 100000);
    err_total++;
    tally_and_finish();
  end

  // inputs move 1 ns after the edge to stay clear of sampling
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_valid();
    for (int n = 0; n < 6000 && angle_valid_o !== 1'b1; n++) step();
  endtask

  // one polling round: set up, move magnet, pulse supply, watch wake
  task automatic run_row(input rpw_row_t r);
    logic seen_d;
    logic seen_h;
    rstn_i = 1'b0;
    magnet = r.ref_a;
    thr = r.thr;
    trim = r.trim;
    poll = 1'b0;
    lp = 1'b0;
    repeat (5) step();
    check_bit(lnk.wake_line, 1'b1);
    rstn_i = 1'b1;
    repeat (45) step();
    check_bit(lnk.cmd_ready, 1'b0);
    for (int n = 0; n < 20000 && setup_done !== 1'b1; n++) step();
    check_bit(setup_done, 1'b1);
    // tracking from zero takes the short way, so upper-half references wrap down once
    check_byte(turns, r.ref_a[7] ? 8'hFF : 8'h00);
    magnet = r.new_a;
    for (int n = 0; n < 20000 && lnk.angle !== r.new_a; n++) step();
    check_bit(lnk.locked, 1'b1);
    check_byte(lnk.angle, r.new_a);
    repeat (20) step();
    poll = 1'b1;
    seen_d = 1'b0;
    seen_h = 1'b0;
    repeat (3000) begin
      step();
      seen_d |= wake_event;
      seen_h |= wake_seen;
    end
    check_bit(seen_d, r.wake);
    check_bit(seen_h, r.wake);
    poll = 1'b0;
    wait_valid();
    check_byte(angle_o, r.new_a);
    $display("row ref %h new %h thr %h done", r.ref_a, r.new_a, r.thr);
  endtask

  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    err_total = 0;
    checks_done = 0;
    rstn_i = 1'b0;
    magnet = 8'h00;
    thr = 8'h00;
    trim = 9'h100;
    poll = 1'b0;
    lp = 1'b0;
    rows[0] = '{8'h03, 8'h08, 8'h01, 9'h000, 1'b0};
    rows[1] = '{8'h03, 8'h08, 8'h04, 9'h100, 1'b1};
    rows[2] = '{8'h03, 8'h07, 8'h04, 9'h100, 1'b0};
    rows[3] = '{8'hFE, 8'h02, 8'h03, 9'h100, 1'b1};
    rows[4] = '{8'hFE, 8'h02, 8'h04, 9'h100, 1'b0};
    rows[5] = '{8'h05, 8'h01, 8'h03, 9'h100, 1'b1};
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    // low power: angle must freeze while the magnet moves on
    lp = 1'b1;
    for (int n = 0; n < 2000 && low_power !== 1'b1; n++) step();
    check_bit(low_power, 1'b1);
    check_bit(lnk.angle_valid, 1'b0);
    magnet = 8'h04;
    repeat (600) step();
    check_byte(lnk.angle, 8'h01);
    lp = 1'b0;
    step();
    wait_valid();
    check_bit(angle_valid_o, 1'b1);
    check_byte(angle_o, 8'h04);
    $display("low power test done");
    tally_and_finish();
  end
endmodule
